//--- verilog/gp_timer_freerun_wordswap.sv
// Host-visible timer, free-running counter and word-order control
module gp_timer_freerun_wordswap #(
  parameter int TICK_DIV = gp_timer_pkg::TIMER_TICK_DIV
) (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic                    soft_reset,
  input  wire gp_timer_pkg::host_req_t host_req,
  output logic [15:0]                  host_data_out,
  output logic                         host_data_oe_n,
  output logic                         timer_event,
  input  wire logic [31:0]             tx_entry,
  input  wire logic                    tx_entry_valid,
  output logic                         tx_entry_ready,
  output logic [15:0]                  net_tx_word,
  output logic                         net_tx_valid,
  input  wire logic                    net_tx_ready,
  input  wire logic [15:0]             net_rx_word,
  input  wire logic                    net_rx_valid,
  output logic [31:0]                  rx_entry,
  output logic                         rx_entry_valid
);
  import gp_timer_pkg::*;

  bus_state_t  bus_state;
  logic        timer_run;
  logic [15:0] timer_preload_value;
  logic [15:0] timer_current_count;
  logic [31:0] host_word_order;
  logic [31:0] freerun_tick_count;
  logic [31:0] freerun_latch;
  logic        freerun_latched;
  logic        freerun_tick;
  logic        timer_tick;
  logic        access_start;
  logic        rd_start;
  logic        wr_start;
  logic        upper_half;
  logic [5:0]  word_addr;
  logic [31:0] read_word;
  logic        hit_config;
  logic        hit_count;
  logic        hit_order;
  logic        hit_freerun;
  logic        config_upper_wr;
  logic        config_lower_wr;
  logic        next_run;
  logic        timer_expire;

  // ----------------------------------------------------------------
  // Rate enables
  // ----------------------------------------------------------------
  tick_divider #(
    .DIV (FREERUN_DIV)
  ) u_freerun_div (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .restart (soft_reset),
    .tick    (freerun_tick)
  );

  // Timer tick period is a choice; shorten TICK_DIV in simulation
  tick_divider #(
    .DIV (TICK_DIV)
  ) u_timer_div (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .restart (soft_reset),
    .tick    (timer_tick)
  );

  // ----------------------------------------------------------------
  // Queue half-word ordering
  // ----------------------------------------------------------------
  queue_word_order u_queue_order (
    .sys_clk        (sys_clk),
    .arst_n         (arst_n),
    .restart        (soft_reset),
    .tx_entry       (tx_entry),
    .tx_entry_valid (tx_entry_valid),
    .tx_entry_ready (tx_entry_ready),
    .net_tx_word    (net_tx_word),
    .net_tx_valid   (net_tx_valid),
    .net_tx_ready   (net_tx_ready),
    .net_rx_word    (net_rx_word),
    .net_rx_valid   (net_rx_valid),
    .rx_entry       (rx_entry),
    .rx_entry_valid (rx_entry_valid)
  );

  // ----------------------------------------------------------------
  // Address decode and half selection
  // ----------------------------------------------------------------
  assign word_addr    = host_req.addr[7:2];
  assign access_start = (bus_state == BUS_IDLE) && !host_req.cs_n;
  assign rd_start     = access_start && !host_req.rd_n;
  assign wr_start     = access_start && host_req.rd_n && !host_req.wr_n;

  // Only the exact all-ones pattern swaps; anything else is normal
  assign upper_half = (host_word_order == WORD_ORDER_SWAP)
                    ? !host_req.addr[1]
                    : host_req.addr[1];

  // One select per word; unmapped words hit nothing
  always_comb begin
    hit_config  = 1'b0;
    hit_count   = 1'b0;
    hit_order   = 1'b0;
    hit_freerun = 1'b0;
    case (word_addr)
      OFF_TIMER_CONFIG[7:2]: begin
        hit_config = 1'b1;
      end
      OFF_TIMER_COUNT[7:2]: begin
        hit_count = 1'b1;
      end
      OFF_WORD_ORDER[7:2]: begin
        hit_order = 1'b1;
      end
      OFF_FREERUN[7:2]: begin
        hit_freerun = 1'b1;
      end
      default: begin
        hit_config = 1'b0;
      end
    endcase
  end

  assign config_upper_wr = wr_start && hit_config && upper_half;
  assign config_lower_wr = wr_start && hit_config && !upper_half;

  assign timer_expire = timer_run && timer_tick
                      && (timer_current_count == COUNT_ZERO);

  // Run bit sits in the upper half at bit 29
  assign next_run = config_upper_wr
                  ? host_req.data[TCFG_RUN_BIT-HALF_W]
                  : timer_run;

  // Reserved bits read as zero
  always_comb begin
    read_word = {2*HALF_W{1'b0}};
    if (hit_config) begin
      read_word[TCFG_RUN_BIT] = timer_run;
      read_word[PRELOAD_LSB +: HALF_W] = timer_preload_value;
    end else if (hit_count) begin
      read_word[HALF_W-1:0] = timer_current_count;
    end else if (hit_order) begin
      read_word = host_word_order;
    end else if (hit_freerun) begin
      // Second half of a pair comes from the held copy
      read_word = freerun_latched ? freerun_latch
                                  : freerun_tick_count;
    end
  end

  // ----------------------------------------------------------------
  // Host bus sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state <= BUS_IDLE;
    end else if (soft_reset) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (rd_start) begin
            bus_state <= BUS_READ;
          end else if (wr_start) begin
            bus_state <= BUS_WRITE;
          end
        end
        BUS_READ: begin
          if (host_req.cs_n || host_req.rd_n) begin
            bus_state <= BUS_IDLE;
          end
        end
        BUS_WRITE: begin
          if (host_req.cs_n || host_req.wr_n) begin
            bus_state <= BUS_IDLE;
          end
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Drive ends the edge after the strobe lifts, never later
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_data_out  <= READ_UNMAPPED;
      host_data_oe_n <= 1'b1;
    end else if (soft_reset) begin
      host_data_oe_n <= 1'b1;
    end else if (rd_start) begin
      host_data_oe_n <= 1'b0;
      host_data_out  <= upper_half
                      ? read_word[2*HALF_W-1:HALF_W]
                      : read_word[HALF_W-1:0];
    end else if (bus_state != BUS_READ
                 || host_req.cs_n || host_req.rd_n) begin
      host_data_oe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Word order register
  // ----------------------------------------------------------------
  // Deliberately blind to soft_reset so software keeps its mapping
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_word_order <= WORD_ORDER_RESET;
    end else if (wr_start && hit_order) begin
      if (upper_half) begin
        host_word_order[2*HALF_W-1:HALF_W] <= host_req.data;
      end else begin
        host_word_order[HALF_W-1:0] <= host_req.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer configuration
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_run           <= 1'b0;
      timer_preload_value <= PRELOAD_RESET;
    end else if (soft_reset) begin
      timer_run           <= 1'b0;
      timer_preload_value <= PRELOAD_RESET;
    end else begin
      timer_run <= next_run;
      if (timer_run && !next_run) begin
        timer_preload_value <= PRELOAD_RESET;
      end else if (config_lower_wr) begin
        timer_preload_value <= host_req.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer count
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_current_count <= COUNT_RESET;
    end else if (soft_reset) begin
      timer_current_count <= COUNT_RESET;
    end else if (!timer_run && next_run) begin
      timer_current_count <= timer_preload_value;
    end else if (timer_expire) begin
      timer_current_count <= timer_preload_value;
    end else if (timer_run && timer_tick) begin
      timer_current_count <= timer_current_count - COUNT_STEP;
    end
  end

  // Pulse feeds the host interrupt status outside
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_event <= 1'b0;
    end else if (soft_reset) begin
      timer_event <= 1'b0;
    end else begin
      timer_event <= timer_expire;
    end
  end

  // ----------------------------------------------------------------
  // Free-running counter and read latch
  // ----------------------------------------------------------------
  // No power state input: the count never gates off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      freerun_tick_count <= FREERUN_RESET;
    end else if (soft_reset) begin
      // Clears within one cycle, well inside the host's wait
      freerun_tick_count <= FREERUN_RESET;
    end else if (freerun_tick) begin
      freerun_tick_count <= freerun_tick_count + FREERUN_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      freerun_latch   <= FREERUN_RESET;
      freerun_latched <= 1'b0;
    end else if (soft_reset) begin
      freerun_latched <= 1'b0;
    end else if (rd_start && hit_freerun) begin
      if (!freerun_latched) begin
        freerun_latch   <= freerun_tick_count;
        freerun_latched <= 1'b1;
      end else begin
        freerun_latched <= 1'b0;
      end
    end
  end

endmodule

//--- verilog/gp_timer_pkg.sv
// Constants, types and register map of the timer and word-order block
package gp_timer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int FREERUN_PERIOD_NS = 40;
  localparam int FREERUN_DIV       = FREERUN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TIMER_TICK_NS     = 100000;
  localparam int TIMER_TICK_DIV    = TIMER_TICK_NS / CLK_PERIOD_NS;
  localparam int FREERUN_CLEAR_NS  = 160;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TIMER_CONFIG  = 8'h8c;
  localparam logic [7:0] OFF_TIMER_COUNT   = 8'h90;
  localparam logic [7:0] OFF_WORD_ORDER    = 8'h98;
  localparam logic [7:0] OFF_FREERUN       = 8'h9c;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          HALF_W            = 16;
  localparam int          TCFG_RUN_BIT      = 29;
  localparam int          PRELOAD_LSB       = 0;
  localparam logic [15:0] PRELOAD_RESET     = 16'hffff;
  localparam logic [15:0] COUNT_RESET       = 16'hffff;
  localparam logic [15:0] COUNT_ZERO        = 16'h0000;
  localparam logic [15:0] COUNT_STEP        = 16'h0001;
  localparam logic [31:0] WORD_ORDER_RESET  = 32'h00000000;
  localparam logic [31:0] WORD_ORDER_SWAP   = 32'hffffffff;
  localparam logic [31:0] FREERUN_RESET     = 32'h00000000;
  localparam logic [31:0] FREERUN_STEP      = 32'h00000001;
  localparam logic [15:0] READ_UNMAPPED     = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:1]  addr;
    logic [15:0] data;
  } host_req_t;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_READ  = 3'b010,
    BUS_WRITE = 3'b100
  } bus_state_t;

endpackage

//--- verilog/tick_divider.sv
// Divider that gives a one-cycle enable pulse every DIV clocks
module tick_divider #(
  parameter int DIV = 4
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] count;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= ZERO;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= ZERO;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= ZERO;
      tick  <= 1'b1;
    end else begin
      count <= count + ONE;
      tick  <= 1'b0;
    end
  end
endmodule

//--- verilog/queue_word_order.sv
// Fixed lower-word-first ordering between 32-bit queue entries and the link
module queue_word_order
  import gp_timer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        restart,
  input  wire logic [31:0] tx_entry,
  input  wire logic        tx_entry_valid,
  output logic             tx_entry_ready,
  output logic [15:0]      net_tx_word,
  output logic             net_tx_valid,
  input  wire logic        net_tx_ready,
  input  wire logic [15:0] net_rx_word,
  input  wire logic        net_rx_valid,
  output logic [31:0]      rx_entry,
  output logic             rx_entry_valid
);
  logic [15:0] tx_upper;
  logic        tx_second;
  logic        rx_second;
  logic [15:0] rx_lower;

  // ----------------------------------------------------------------
  // Transmit: word order setting never applies here
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_entry_ready <= 1'b1;
      net_tx_valid   <= 1'b0;
      net_tx_word    <= COUNT_ZERO;
      tx_upper       <= COUNT_ZERO;
      tx_second      <= 1'b0;
    end else if (restart) begin
      tx_entry_ready <= 1'b1;
      net_tx_valid   <= 1'b0;
      tx_second      <= 1'b0;
    end else if (tx_entry_valid && tx_entry_ready) begin
      net_tx_word    <= tx_entry[HALF_W-1:0];
      tx_upper       <= tx_entry[2*HALF_W-1:HALF_W];
      net_tx_valid   <= 1'b1;
      tx_entry_ready <= 1'b0;
      tx_second      <= 1'b0;
    end else if (net_tx_valid && net_tx_ready) begin
      if (!tx_second) begin
        net_tx_word <= tx_upper;
        tx_second   <= 1'b1;
      end else begin
        net_tx_valid   <= 1'b0;
        tx_entry_ready <= 1'b1;
        tx_second      <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive: first link word is the lower half
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_second      <= 1'b0;
      rx_lower       <= COUNT_ZERO;
      rx_entry       <= FREERUN_RESET;
      rx_entry_valid <= 1'b0;
    end else if (restart) begin
      rx_second      <= 1'b0;
      rx_entry_valid <= 1'b0;
    end else begin
      rx_entry_valid <= 1'b0;
      if (net_rx_valid) begin
        if (!rx_second) begin
          rx_lower  <= net_rx_word;
          rx_second <= 1'b1;
        end else begin
          rx_entry       <= {net_rx_word, rx_lower};
          rx_entry_valid <= 1'b1;
          rx_second      <= 1'b0;
        end
      end
    end
  end
endmodule

//--- verification/gp_timer_props.sv
// Port-level checker for the timer, word-order and queue block
module gp_timer_props
  import gp_timer_pkg::*;
#(
  parameter int TICK_DIV = 4
) (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        soft_reset,
  input wire host_req_t   host_req,
  input wire logic        host_data_oe_n,
  input wire logic        timer_event,
  input wire logic [31:0] tx_entry,
  input wire logic        tx_entry_valid,
  input wire logic        tx_entry_ready,
  input wire logic [15:0] net_tx_word,
  input wire logic        net_tx_valid,
  input wire logic        net_tx_ready,
  input wire logic [15:0] net_rx_word,
  input wire logic        net_rx_valid,
  input wire logic [31:0] rx_entry,
  input wire logic        rx_entry_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n || soft_reset);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic        rd_req;
  logic [15:0] tx_hi;
  logic        tx_ph;
  logic [15:0] rx_lo;
  logic        rx_odd;
  assign rd_req = !host_req.cs_n && !host_req.rd_n;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_hi <= 16'h0000;
      tx_ph <= 1'b0;
    end else if (soft_reset) begin
      tx_ph <= 1'b0;
    end else if (tx_entry_valid && tx_entry_ready) begin
      tx_hi <= tx_entry[31:16];
      tx_ph <= 1'b0;
    end else if (net_tx_valid && net_tx_ready) begin
      tx_ph <= ~tx_ph;
    end
  end
  // Odd word parity; soft reset drops a waiting half
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_lo  <= 16'h0000;
      rx_odd <= 1'b0;
    end else if (soft_reset) begin
      rx_odd <= 1'b0;
    end else if (net_rx_valid) begin
      rx_odd <= ~rx_odd;
      if (!rx_odd) begin
        rx_lo <= net_rx_word;
      end
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_drive_on_a: assert property ($rose(rd_req) |=> !host_data_oe_n)
    else $error("read data not driven one cycle after strobe");
  read_drive_off_a: assert property
    (!host_data_oe_n && !rd_req |=> host_data_oe_n)
    else $error("data drive held after strobe release");
  idle_no_drive_a: assert property
    (host_data_oe_n && !rd_req |=> host_data_oe_n)
    else $error("data driven without a read");
  event_pulse_a: assert property (timer_event |=> !timer_event)
    else $error("timer event longer than one cycle");
  tx_word_hold_a: assert property (net_tx_valid && !net_tx_ready
    |=> net_tx_valid && $stable(net_tx_word))
    else $error("transmit word dropped or changed while stalled");
  tx_low_first_a: assert property (tx_entry_valid && tx_entry_ready
    |=> net_tx_valid && !tx_entry_ready &&
        net_tx_word == $past(tx_entry[15:0]))
    else $error("transmit entry did not start with lower word");
  tx_high_second_a: assert property
    (net_tx_valid && tx_ph |-> net_tx_word == tx_hi)
    else $error("second transmit word is not upper half");
  rx_pair_a: assert property (net_rx_valid && rx_odd
    |=> rx_entry_valid && rx_entry == {$past(net_rx_word), rx_lo})
    else $error("receive entry not lower word first");
  rx_no_half_a: assert property
    (net_rx_valid && !rx_odd |=> !rx_entry_valid)
    else $error("receive entry completed after one word");
  cover property ($rose(rd_req));
  cover property (timer_event);
  cover property (tx_entry_valid && tx_entry_ready);
  cover property (rx_entry_valid);
endmodule

bind gp_timer_freerun_wordswap gp_timer_props #(
  .TICK_DIV(TICK_DIV)
) props_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .soft_reset(soft_reset),
  .host_req(host_req), .host_data_oe_n(host_data_oe_n),
  .timer_event(timer_event), .tx_entry(tx_entry),
  .tx_entry_valid(tx_entry_valid), .tx_entry_ready(tx_entry_ready),
  .net_tx_word(net_tx_word), .net_tx_valid(net_tx_valid),
  .net_tx_ready(net_tx_ready), .net_rx_word(net_rx_word),
  .net_rx_valid(net_rx_valid), .rx_entry(rx_entry),
  .rx_entry_valid(rx_entry_valid)
);

//--- verification/host_model.sv
// Host processor model on the 16-bit SRAM-like register bus
module host_model
  import gp_timer_pkg::*;
(
  input  wire logic        sys_clk,
  output host_req_t        host_req,
  input  wire logic [15:0] host_data_out,
  input  wire logic        host_data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_req = {3'b111, 7'h00, 16'h0000};
  // Write commits at strobe start; data released to its inverse
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    host_req = {3'b010, a[7:1], d};
    @(posedge sys_clk);
    @(negedge sys_clk);
    host_req = {3'b111, ~a[7:1], ~d};
    @(negedge sys_clk);
  endtask
  // Strobe held until the drive enable is seen low at an edge, for at most 8 edges
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    host_req = {3'b001, a[7:1], ~host_req.data};
    do begin
      @(posedge sys_clk);
      n++;
    end while (host_data_oe_n !== 1'b0 && n < 8);
    d = host_data_oe_n === 1'b0 ? host_data_out : 16'hxxxx;
    @(negedge sys_clk);
    host_req = {3'b111, ~a[7:1], ~host_req.data};
    @(negedge sys_clk);
  endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the timer, word-order and queue block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gp_timer_pkg::*;
  localparam int TD = 4;
  logic        sys_clk = 0, arst_n = 0, soft_reset = 0, swap = 0;
  host_req_t   host_req;
  logic [15:0] host_data_out, net_tx_word, net_rx_word, d, e, p;
  logic        host_data_oe_n, timer_event, tx_entry_ready, net_tx_valid;
  logic        net_tx_ready = 0, tx_entry_valid, net_rx_valid;
  logic        rx_entry_valid;
  logic [31:0] tx_entry, rx_entry, v, rx_got;
  logic [15:0] txq[$];
  int          err_total, check_count, cyc, n;
  gp_timer_freerun_wordswap #(.TICK_DIV(TD)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .soft_reset(soft_reset),
    .host_req(host_req), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .timer_event(timer_event),
    .tx_entry(tx_entry), .tx_entry_valid(tx_entry_valid),
    .tx_entry_ready(tx_entry_ready), .net_tx_word(net_tx_word),
    .net_tx_valid(net_tx_valid), .net_tx_ready(net_tx_ready),
    .net_rx_word(net_rx_word), .net_rx_valid(net_rx_valid),
    .rx_entry(rx_entry), .rx_entry_valid(rx_entry_valid));
  host_model host_u (.sys_clk(sys_clk), .host_req(host_req),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n));
  // ----------------------------------------------------------------
  // Clock, far-side link and monitors
  // ----------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;
  // Random stalls on the link side
  always @(negedge sys_clk) net_tx_ready <= 1'($urandom_range(0, 1));
  always @(posedge sys_clk) begin
    if (net_tx_valid === 1'b1 && net_tx_ready) txq.push_back(net_tx_word);
    if (rx_entry_valid === 1'b1) rx_got <= rx_entry;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bus address of one half, bent by the word-order setting
  function automatic logic [7:0] ha(logic [7:0] b, logic up);
    return b + {6'h00, up ^ swap, 1'b0};
  endfunction
  task automatic wrh(logic [7:0] b, logic up, logic [15:0] x);
    host_u.wr(ha(b, up), x);
  endtask
  task automatic rdh(logic [7:0] b, logic up, output logic [15:0] x);
    host_u.rd(ha(b, up), x);
  endtask
  task automatic sr();
    @(negedge sys_clk) soft_reset = 1;
    @(negedge sys_clk) soft_reset = 0;
  endtask
  task automatic wait_ev(output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (timer_event !== 1'b1 && c < 500);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {tx_entry, tx_entry_valid, net_rx_word, net_rx_valid} = '0;
    void'($urandom(49));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk) arst_n = 1;
    repeat (FREERUN_CLEAR_NS / CLK_PERIOD_NS) @(negedge sys_clk);
    rdh(OFF_TIMER_CONFIG, 0, d);
    chk("preload", d, 16'hffff);
    rdh(OFF_TIMER_CONFIG, 1, d);
    chk("run", d, 16'h0000);
    rdh(OFF_TIMER_COUNT, 0, d);
    chk("count", d, 16'hffff);
    rdh(OFF_WORD_ORDER, 0, d);
    chk("order lo", d, 16'h0000);
    rdh(8'h80, 0, d);
    chk("unmapped", d, 16'h0000);
    sr();
    rdh(OFF_FREERUN, 1, d);
    chk("free hi", d, 16'h0000);
    repeat (400) @(negedge sys_clk);
    rdh(OFF_FREERUN, 0, d);
    chk("free held", d < 16'd8, 1);
    rdh(OFF_FREERUN, 0, d);
    chk("free rate", d >= 16'd95 && d <= 16'd115, 1);
    wrh(OFF_WORD_ORDER, 0, 16'hffff);
    wrh(OFF_WORD_ORDER, 1, 16'hffff);
    swap = 1;
    sr();
    rdh(OFF_WORD_ORDER, 0, d);
    chk("order kept", d, 16'hffff);
    rdh(OFF_TIMER_CONFIG, 0, d);
    chk("swap lo", d, 16'hffff);
    rdh(OFF_TIMER_CONFIG, 1, d);
    chk("swap hi", d, 16'h0000);
    for (int o = 0; o < 2; o++) begin
      p = 16'($urandom_range(1, 4));
      wrh(OFF_TIMER_CONFIG, 0, p);
      rdh(OFF_TIMER_CONFIG, 0, d);
      chk("preload wr", d, p);
      wrh(OFF_TIMER_CONFIG, 1, 16'h2000);
      wait_ev(n);
      wait_ev(n);
      chk("period", n, (p + 1) * TD);
      rdh(OFF_TIMER_COUNT, 0, d);
      chk("count rng", d <= p, 1);
      wrh(OFF_TIMER_CONFIG, 1, 16'h0000);
      rdh(OFF_TIMER_CONFIG, 0, d);
      chk("halt load", d, 16'hffff);
      rdh(OFF_TIMER_COUNT, 0, d);
      repeat (3 * TD) @(negedge sys_clk);
      rdh(OFF_TIMER_COUNT, 0, e);
      chk("halted", e, d);
      v = $urandom;
      @(negedge sys_clk) {tx_entry, tx_entry_valid} = {v, 1'b1};
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (tx_entry_ready !== 1'b1 && n < 50);
      @(negedge sys_clk) {tx_entry, tx_entry_valid} = {~v, 1'b0};
      v = $urandom;
      @(negedge sys_clk) {net_rx_word, net_rx_valid} = {v[15:0], 1'b1};
      @(negedge sys_clk) net_rx_word = v[31:16];
      @(negedge sys_clk) {net_rx_word, net_rx_valid} = {~v[31:16], 1'b0};
      repeat (40) @(negedge sys_clk);
      chk("rx entry", rx_got, v);
      chk("tx lo", txq.size() == 2 ? txq[0] : 16'hxxxx,
          tx_entry[15:0] ^ 16'hffff);
      chk("tx hi", txq.size() == 2 ? txq[1] : 16'hxxxx,
          tx_entry[31:16] ^ 16'hffff);
      txq.delete();
      wrh(OFF_WORD_ORDER, 0, 16'h0000);
      wrh(OFF_WORD_ORDER, 1, 16'h0000);
      swap = 0;
    end
    finish_test();
  end
endmodule
